// File: rtl/scm_clock_ctrl.sv
// System clock selection and operating mode sequencer with an APB slave.
// Assumes halt_req comes from the CPU on sys_clk and wake_pin is a pin.
`timescale 1ns/1ps
`include "scm_regs.svh"
module scm_clock_ctrl
    import scm_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic [1:0]  fast_freq_cfg,
    input  wire logic        halt_req,
    input  wire logic        wake_pin,
    output logic             cpu_clk_en,
    output logic             sys_clk_en,
    output logic             stand_in_clk_en,
    output logic             periph_slow_clk_en,
    output logic             sense_clk_en,
    output logic             wdt_clk_en,
    output logic [2:0]       op_mode
);
    // ***********************************************************
    // Declarations
    // ***********************************************************
    scm_mode_t   state_reg;
    scm_mode_t   state_next;
    logic [7:0]  ctrl_reg;
    logic [2:0]  ext_reg;
    logic [1:0]  cfg_reg;
    logic        cfg_done_reg;
    logic [3:0]  cfg_sync_reg;
    logic [1:0]  wake_sync_reg;
    logic        act_speed_reg;
    logic [2:0]  act_ssel_reg;
    logic [5:0]  div_cnt_reg;
    logic [3:0]  frdy_cnt_reg;
    logic        srdy_cnt_reg;
    logic        fast_osc_ready;
    logic        slow_osc_ready;
    logic [31:0] prdata_reg;
    logic [16:0] fast_step;
    logic        fast_run;
    logic        slow_run;
    logic        fast_pulse;
    logic        slow_pulse;
    logic        rc_sel;
    logic [6:0]  div_ratio;
    logic [5:0]  div_last;
    logic        div_pulse;
    logic        slow_src_pulse;
    logic        sys_src_pulse;
    logic        src_running;
    logic        switch_ok;
    logic        run_mode;
    logic        halted;
    logic        sys_on;
    logic        periph_on;
    logic        sense_on;
    logic        wake;
    logic        setup;
    logic        access;
    logic        hit_mode;
    logic        hit_ext;
    logic        hit_stat;
    logic        mapped;
    logic        speed_sel;
    logic        idle_allow;
    logic [2:0]  slow_clock_select;
    logic        sysclk_keep_on;
    logic        lowvolt_detect_enable;
    logic        wdt_enable;

    // ***********************************************************
    // Register fields
    // ***********************************************************
    assign speed_sel             = ctrl_reg[`SCM_MODE_SPEED];
    assign idle_allow            = ctrl_reg[`SCM_MODE_IDLE];
    assign slow_clock_select     = ctrl_reg[`SCM_MODE_SSEL_LSB +: 3];
    assign sysclk_keep_on        = ext_reg[`SCM_EXT_KEEP];
    assign lowvolt_detect_enable = ext_reg[`SCM_EXT_LVD];
    assign wdt_enable            = ext_reg[`SCM_EXT_WDT];

    // ***********************************************************
    // Strap capture and wake synchroniser
    // ***********************************************************
    // The frequency strap is a build option, so it is caught once after
    // reset and later changes of the pin are ignored.
    always_ff @(posedge sys_clk) begin
        cfg_sync_reg <= {cfg_sync_reg[1:0], fast_freq_cfg};
    end
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_reg      <= 2'h0;
            cfg_done_reg <= 1'b0;
        end else if (!cfg_done_reg) begin
            cfg_reg      <= cfg_sync_reg[3:2];
            cfg_done_reg <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wake_sync_reg <= 2'h0;
        end else begin
            wake_sync_reg <= {wake_sync_reg[0], wake_pin};
        end
    end
    assign wake = wake_sync_reg[1];

    // ***********************************************************
    // Oscillators
    // ***********************************************************
    always_comb begin
        case (cfg_reg)
            2'h0:    fast_step = `SCM_FAST2_KHZ;
            2'h1:    fast_step = `SCM_FAST4_KHZ;
            default: fast_step = `SCM_FAST8_KHZ;
        endcase
    end

    assign run_mode  = (state_reg == SCM_FAST) || (state_reg == SCM_SLOW);
    assign halted    = !run_mode;
    // The fast oscillator runs only in FAST, SLOW and IDLE1, the slow one in every mode but SLEEP0.
    assign fast_run  = cfg_done_reg && (run_mode ||
                       state_reg == SCM_IDLE1);
    assign slow_run  = state_reg != SCM_SLEEP0;

    scm_rc_osc u_fast_osc (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .run     (fast_run),
        .step    (fast_step),
        .pulse   (fast_pulse)
    );

    scm_rc_osc u_slow_osc (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .run     (slow_run),
        .step    (`SCM_SLOW_KHZ),
        .pulse   (slow_pulse)
    );

    // ***********************************************************
    // Slow clock divider and source selection
    // ***********************************************************
    assign rc_sel    = act_ssel_reg[2:1] == 2'h0;
    assign div_ratio = 7'h02 << (3'h7 - act_ssel_reg);
    assign div_last  = 6'(div_ratio - 7'h01);
    assign div_pulse = fast_pulse && (div_cnt_reg == div_last);

    assign slow_src_pulse = rc_sel ? slow_pulse : div_pulse;
    assign sys_src_pulse  = act_speed_reg ? fast_pulse
                                          : slow_src_pulse;
    assign src_running    = (act_speed_reg || !rc_sel) ? fast_run
                                                       : slow_run;
    // A new choice only takes over at the end of a whole period of the
    // old source, or at once while that source is stopped, so no shortened clock pulse reaches the CPU.
    assign switch_ok = sys_src_pulse || !src_running;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            act_speed_reg <= 1'(`SCM_MODE_RST >> `SCM_MODE_SPEED);
            act_ssel_reg  <= 3'h0;
        end else if (switch_ok) begin
            act_speed_reg <= speed_sel;
            act_ssel_reg  <= slow_clock_select;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt_reg <= 6'h00;
        end else if (switch_ok && act_ssel_reg != slow_clock_select) begin
            div_cnt_reg <= 6'h00;
        end else if (fast_pulse) begin
            div_cnt_reg <= div_pulse ? 6'h00 : div_cnt_reg + 6'h01;
        end
    end

    // ***********************************************************
    // Operating mode sequencer
    // ***********************************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SCM_FAST, SCM_SLOW: begin
                if (halt_req && idle_allow) begin
                    state_next = sysclk_keep_on ? SCM_IDLE1
                                                : SCM_IDLE0;
                end else if (halt_req) begin
                    state_next = (lowvolt_detect_enable || wdt_enable)
                               ? SCM_SLEEP1 : SCM_SLEEP0;
                end else begin
                    state_next = (switch_ok ? speed_sel : act_speed_reg)
                               ? SCM_FAST : SCM_SLOW;
                end
            end
            SCM_IDLE0, SCM_IDLE1, SCM_SLEEP0, SCM_SLEEP1: begin
                if (wake) begin
                    state_next = (switch_ok ? speed_sel : act_speed_reg)
                               ? SCM_FAST : SCM_SLOW;
                end
            end
            default: state_next = SCM_FAST;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= SCM_FAST;
        end else begin
            state_reg <= state_next;
        end
    end

    // ***********************************************************
    // Clock enables
    // ***********************************************************
    assign sys_on    = run_mode || state_reg == SCM_IDLE1;
    assign periph_on = state_reg != SCM_SLEEP0;
    assign sense_on  = state_reg == SCM_IDLE0 ||
                       state_reg == SCM_IDLE1 ||
                       state_reg == SCM_SLEEP1;

    assign sys_clk_en         = sys_on && sys_src_pulse;
    assign cpu_clk_en         = run_mode && sys_src_pulse;
    assign stand_in_clk_en    = periph_on && slow_pulse;
    assign periph_slow_clk_en = periph_on && slow_pulse;
    assign sense_clk_en       = sense_on && slow_pulse;
    // The watchdog ticks from the stand-in clock and dies in deep sleep.
    assign wdt_clk_en         = wdt_enable && stand_in_clk_en;
    assign op_mode            = state_reg;

    // ***********************************************************
    // Oscillator ready flags
    // ***********************************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            frdy_cnt_reg   <= 4'h0;
            fast_osc_ready <= 1'b0;
        end else if (!fast_run) begin
            frdy_cnt_reg   <= 4'h0;
            fast_osc_ready <= 1'b0;
        end else if (fast_pulse && !fast_osc_ready) begin
            frdy_cnt_reg   <= frdy_cnt_reg + 4'h1;
            if (frdy_cnt_reg == `SCM_FAST_RDY_LAST) begin
                fast_osc_ready <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            srdy_cnt_reg   <= 1'b0;
            slow_osc_ready <= 1'b0;
        end else if (!slow_run) begin
            srdy_cnt_reg   <= 1'b0;
            slow_osc_ready <= 1'b0;
        end else if (slow_pulse && !slow_osc_ready) begin
            srdy_cnt_reg   <= 1'b1;
            if (srdy_cnt_reg == `SCM_SLOW_RDY_LAST) begin
                slow_osc_ready <= 1'b1;
            end
        end
    end

    // ***********************************************************
    // APB slave
    // ***********************************************************
    assign setup    = psel && !penable;
    assign access   = psel && penable;
    assign hit_mode = paddr == `SCM_ADDR_MODE;
    assign hit_ext  = paddr == `SCM_ADDR_EXT;
    assign hit_stat = paddr == `SCM_ADDR_STAT;
    assign mapped   = hit_mode || hit_ext || hit_stat;
    assign pready   = 1'b1;
    assign pslverr  = access && !mapped;
    assign prdata   = prdata_reg;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= `SCM_MODE_RST;
            ext_reg  <= `SCM_EXT_RST;
        end else if (access && pwrite) begin
            if (hit_mode) begin
                ctrl_reg <= {pwdata[7:5], 3'h0, pwdata[1:0]};
            end
            if (hit_ext) begin
                ext_reg <= pwdata[2:0];
            end
        end
    end

    // Read data is fetched in the setup cycle so that it already sits
    // in a flip-flop when the zero-wait access phase completes.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_reg <= 32'h00000000;
        end else if (setup && !pwrite) begin
            prdata_reg <= 32'h00000000;
            if (hit_mode) begin
                prdata_reg[7:0] <= {ctrl_reg[7:5], 1'b0, slow_osc_ready,
                                    fast_osc_ready, ctrl_reg[1:0]};
            end
            if (hit_ext) begin
                prdata_reg[2:0] <= ext_reg;
            end
            if (hit_stat) begin
                prdata_reg[3:0] <= {act_speed_reg, state_reg};
            end
        end
    end

    // ***********************************************************
    // Checks
    // ***********************************************************
    sequence s_halt_sleep;
        run_mode && halt_req && !idle_allow;
    endsequence

    sequence s_leave_deep;
        state_reg == SCM_SLEEP0 ##1 state_reg != SCM_SLEEP0;
    endsequence

    AST_SLEEP0_QUIET: assert property (@(posedge sys_clk) disable iff
        (!reset_n) state_reg == SCM_SLEEP0 |-> !stand_in_clk_en &&
        !sense_clk_en && !sys_clk_en && !wdt_clk_en)
        else $error("clock runs in deep sleep");
    AST_LVD_BLOCKS_SLEEP0: assert property (@(posedge sys_clk) disable iff
        (!reset_n) s_halt_sleep and lowvolt_detect_enable
        |=> state_reg == SCM_SLEEP1)
        else $error("deep sleep entered with detector on");
    AST_IDLE0_ENTRY: assert property (@(posedge sys_clk) disable iff
        (!reset_n) run_mode && halt_req && idle_allow && !sysclk_keep_on
        |=> state_reg == SCM_IDLE0 && !sys_clk_en)
        else $error("idle0 not entered");
    AST_IDLE1_ENTRY: assert property (@(posedge sys_clk) disable iff
        (!reset_n) run_mode && halt_req && idle_allow && sysclk_keep_on
        |=> state_reg == SCM_IDLE1 && fast_run)
        else $error("idle1 not entered");
    AST_SENSE_HALT_ONLY: assert property (@(posedge sys_clk) disable iff
        (!reset_n) sense_clk_en |-> halted && slow_pulse)
        else $error("sensing clock while cpu runs");
    AST_CPU_RUN_ONLY: assert property (@(posedge sys_clk) disable iff
        (!reset_n) cpu_clk_en |-> run_mode && (state_reg == SCM_FAST
        ? fast_pulse : slow_src_pulse))
        else $error("cpu clock from wrong source");
    AST_FAST_RDY_LOW: assert property (@(posedge sys_clk) disable iff
        (!reset_n) state_reg == SCM_IDLE0 || state_reg == SCM_SLEEP0 ||
        state_reg == SCM_SLEEP1 |=> !fast_osc_ready)
        else $error("fast ready while stopped");
    AST_SLOW_RDY_WAKE: assert property (@(posedge sys_clk) disable iff
        (!reset_n) s_leave_deep |-> !slow_osc_ready)
        else $error("slow ready too early after deep sleep");
    AST_SWITCH_CLEAN: assert property (@(posedge sys_clk) disable iff
        (!reset_n) $changed(act_speed_reg) |-> $past(switch_ok))
        else $error("clock switched mid period");
    AST_RC_SELECT: assert property (@(posedge sys_clk) disable iff
        (!reset_n) !act_speed_reg && rc_sel && sys_clk_en |-> slow_pulse)
        else $error("slow oscillator not used as slow clock");
endmodule

// File: rtl/scm_pkg.sv
// Types shared by the clock and mode control block.
// Assumes nothing of its surroundings.
package scm_pkg;
    typedef enum logic [2:0] {
        SCM_FAST   = 3'b000,
        SCM_SLOW   = 3'b001,
        SCM_IDLE0  = 3'b010,
        SCM_IDLE1  = 3'b011,
        SCM_SLEEP0 = 3'b100,
        SCM_SLEEP1 = 3'b101
    } scm_mode_t;
endpackage

// File: rtl/scm_rc_osc.sv
// Phase accumulator that stands for one internal RC oscillator.
// Assumes step is far below the sys_clk rate in kHz.
`timescale 1ns/1ps
`include "scm_regs.svh"
module scm_rc_osc
    import scm_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        run,
    input  wire logic [16:0] step,
    output logic             pulse
);
    logic [16:0] acc_reg;
    logic [17:0] acc_sum;

    // A stopped oscillator restarts from zero phase, as a real one would.
    assign acc_sum = {1'b0, acc_reg} + {1'b0, step};
    assign pulse   = run && (acc_sum >= {1'b0, `SCM_SYS_KHZ});

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_reg <= 17'h00000;
        end else if (!run) begin
            acc_reg <= 17'h00000;
        end else if (pulse) begin
            acc_reg <= 17'(acc_sum - {1'b0, `SCM_SYS_KHZ});
        end else begin
            acc_reg <= acc_sum[16:0];
        end
    end
endmodule

// File: rtl/scm_regs.svh
// Offsets, field positions, reset values and counts of the clock block.
// Assumes a 100 MHz sys_clk and an APB slave with 12-bit byte addresses.
`ifndef SCM_REGS_SVH
`define SCM_REGS_SVH

// ***********************************************************
// Register map
// ***********************************************************
`define SCM_ADDR_MODE     12'h000
`define SCM_ADDR_EXT      12'h004
`define SCM_ADDR_STAT     12'h008
`define SCM_MODE_SPEED    0
`define SCM_MODE_IDLE     1
`define SCM_MODE_FRDY     2
`define SCM_MODE_SRDY     3
`define SCM_MODE_SSEL_LSB 5
`define SCM_EXT_KEEP      0
`define SCM_EXT_LVD       1
`define SCM_EXT_WDT       2
`define SCM_MODE_RST      8'h03
`define SCM_EXT_RST       3'h0

// ***********************************************************
// Oscillator models and timing
// ***********************************************************
`define SCM_SYS_KHZ       17'h186A0
`define SCM_FAST8_KHZ     17'h01F40
`define SCM_FAST4_KHZ     17'h00FA0
`define SCM_FAST2_KHZ     17'h007D0
`define SCM_SLOW_KHZ      17'h00020
`define SCM_FAST_RDY_LAST 4'hF
`define SCM_SLOW_RDY_LAST 1'h1

`endif

// File: tb/tb_sysclk_source_and_power_modes.sv
// Self-checking bench for the clock selection and operating mode block.
// Assumes the APB slave of the design and a strap fixed after each reset.
`timescale 1ns/1ps
`include "scm_regs.svh"
module tb_sysclk_source_and_power_modes
    import scm_pkg::*;
;
    // ***********************************************************
    // Signals and design instance
    // ***********************************************************
    logic        sys_clk;
    logic        reset_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [1:0]  fast_freq_cfg;
    logic        halt_req;
    logic        wake_pin;
    logic        cpu_clk_en;
    logic        sys_clk_en;
    logic        stand_in_clk_en;
    logic        periph_slow_clk_en;
    logic        sense_clk_en;
    logic        wdt_clk_en;
    logic [2:0]  op_mode;
    int          error_cnt;
    int          check_count;

    scm_clock_ctrl u_dut (
        .sys_clk            (sys_clk),
        .reset_n            (reset_n),
        .psel               (psel),
        .penable            (penable),
        .pwrite             (pwrite),
        .paddr              (paddr),
        .pwdata             (pwdata),
        .pready             (pready),
        .prdata             (prdata),
        .pslverr            (pslverr),
        .fast_freq_cfg      (fast_freq_cfg),
        .halt_req           (halt_req),
        .wake_pin           (wake_pin),
        .cpu_clk_en         (cpu_clk_en),
        .sys_clk_en         (sys_clk_en),
        .stand_in_clk_en    (stand_in_clk_en),
        .periph_slow_clk_en (periph_slow_clk_en),
        .sense_clk_en       (sense_clk_en),
        .wdt_clk_en         (wdt_clk_en),
        .op_mode            (op_mode)
    );

    // ***********************************************************
    // Shared tasks
    // ***********************************************************
    task automatic end_sim();
        if (error_cnt == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi);
        check_count++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    // The request is held until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) begin
            @(posedge sys_clk);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic do_reset(input logic [1:0] cfg);
        @(posedge sys_clk);
        fast_freq_cfg <= cfg;
        reset_n       <= 1'b0;
        repeat (12) @(posedge sys_clk);
        reset_n       <= 1'b1;
    endtask

    task automatic wait_mode(input logic [2:0] m, input int bound);
        int n;
        n = 0;
        @(negedge sys_clk);
        while (op_mode !== m && n < bound) begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    task automatic wait_ready(input int idx, input int bound);
        logic [31:0] d;
        logic        e;
        int          n;
        n = 0;
        d = '0;
        while (d[idx] !== 1'b1 && n < bound) begin
            apb(1'b0, `SCM_ADDR_MODE, 32'h0, d, e);
            n++;
        end
        chk_eq(d[idx], 1'b1);
    endtask

    // Slots: cpu, system, stand-in, peripheral slow, sensing, watchdog.
    task automatic count_en(input int n, output int c[6]);
        c = '{0, 0, 0, 0, 0, 0};
        repeat (n) begin
            @(negedge sys_clk);
            c[0] += int'(cpu_clk_en === 1'b1);
            c[1] += int'(sys_clk_en === 1'b1);
            c[2] += int'(stand_in_clk_en === 1'b1);
            c[3] += int'(periph_slow_clk_en === 1'b1);
            c[4] += int'(sense_clk_en === 1'b1);
            c[5] += int'(wdt_clk_en === 1'b1);
        end
    endtask

    // ***********************************************************
    // Scenarios
    // ***********************************************************
    task automatic t_strap();
        int c[6];
        int f[4] = '{20, 40, 80, 80};
        for (int i = 0; i < 4; i++) begin
            do_reset(2'(i));
            repeat (20) @(posedge sys_clk);
            count_en(1000, c);
            chk_rng(c[0], f[i] - 2, f[i] + 2);
        end
    endtask

    task automatic t_reset();
        logic [31:0] d;
        logic        e;
        do_reset(2'h2);
        apb(1'b0, `SCM_ADDR_MODE, 32'h0, d, e);
        chk_eq(d, 32'h03);
        apb(1'b0, `SCM_ADDR_EXT, 32'h0, d, e);
        chk_eq(d, 32'h00);
        apb(1'b0, `SCM_ADDR_STAT, 32'h0, d, e);
        chk_eq(d, 32'h08);
        apb(1'b1, 12'h00C, 32'hFF, d, e);
        apb(1'b0, 12'h00C, 32'h0, d, e);
        chk_eq({d[30:0], e}, 32'h1);
        wait_ready(2, 400);
        wait_ready(3, 4000);
    endtask

    // Units of 1/256 of a 3200-cycle window at 8 MHz give 256/div pulses.
    task automatic t_slow();
        logic [31:0] d;
        logic        e;
        int          c[6];
        int          dv[8] = '{0, 0, 64, 32, 16, 8, 4, 2};
        logic [2:0]  sl;
        for (int s = 2; s < 9; s++) begin
            sl = 3'(s % 8);
            apb(1'b1, `SCM_ADDR_MODE, {24'h0, sl, 5'h02}, d, e);
            wait_mode(SCM_SLOW, 4000);
            chk_eq(op_mode, SCM_SLOW);
            repeat (50) @(posedge sys_clk);
            count_en(3200, c);
            if (sl == 3'h0) begin
                chk_rng(c[0], 1, 2);
            end else begin
                chk_rng(c[0], 256 / dv[sl] - 2, 256 / dv[sl] + 2);
            end
            chk_eq({c[4] > 0, c[2] > 0, c[3] > 0}, 3'h3);
            apb(1'b0, `SCM_ADDR_STAT, 32'h0, d, e);
            chk_eq(d, 32'h01);
        end
        apb(1'b1, `SCM_ADDR_MODE, 32'h03, d, e);
        wait_mode(SCM_FAST, 4000);
        chk_eq(op_mode, SCM_FAST);
        count_en(4000, c);
        chk_eq({c[0] > 0, c[1] > 0, c[2] > 0, c[3] > 0, c[4] > 0}, 5'h1E);
    endtask

    task automatic t_modes();
        logic [31:0] d;
        logic        e;
        int          c[6];
        logic [7:0]  mv[5] = '{8'h03, 8'h03, 8'h01, 8'h01, 8'h01};
        logic [2:0]  xv[5] = '{3'h1, 3'h4, 3'h2, 3'h4, 3'h0};
        logic [2:0]  em[5] = '{SCM_IDLE1, SCM_IDLE0, SCM_SLEEP1, SCM_SLEEP1,
                               SCM_SLEEP0};
        logic [4:0]  ev[5] = '{5'h0F, 5'h07, 5'h07, 5'h07, 5'h00};
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, `SCM_ADDR_MODE, {24'h0, mv[i]}, d, e);
            apb(1'b1, `SCM_ADDR_EXT, {29'h0, xv[i]}, d, e);
            @(posedge sys_clk);
            halt_req <= 1'b1;
            @(posedge sys_clk);
            halt_req <= 1'b0;
            wait_mode(em[i], 4);
            chk_eq(op_mode, em[i]);
            count_en(4000, c);
            chk_eq({c[0] > 0, c[1] > 0, c[2] > 0, c[3] > 0, c[4] > 0},
                   ev[i]);
            if (i == 0) chk_eq(c[1] > 0, 1'b1);
            if (i == 1) chk_eq(c[5] > 0, 1'b1);
            if (i == 2) chk_eq(op_mode, SCM_SLEEP1);
            if (i == 3) chk_eq(c[2] > 0, 1'b1);
            if (i == 4) chk_eq(c[5], 0);
            apb(1'b0, `SCM_ADDR_MODE, 32'h0, d, e);
            if (i != 0) chk_eq(d[2], 1'b0);
            if (i == 4) chk_eq(d[3], 1'b0);
            @(posedge sys_clk);
            wake_pin <= 1'b1;
            wait_mode(SCM_FAST, 10);
            chk_eq(op_mode, SCM_FAST);
            @(posedge sys_clk);
            wake_pin <= 1'b0;
            wait_ready(2, 300);
        end
    endtask

    // ***********************************************************
    // Clock, watchdog and main sequence
    // ***********************************************************
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Every scenario together stays well below this many cycles.
    initial begin
        repeat (90000) @(posedge sys_clk);
        error_cnt++;
        end_sim();
    end

    initial begin
        reset_n       = 1'b0;
        psel          = 1'b0;
        penable       = 1'b0;
        pwrite        = 1'b0;
        paddr         = 12'h000;
        pwdata        = 32'h0;
        fast_freq_cfg = 2'h2;
        halt_req      = 1'b0;
        wake_pin      = 1'b0;
        error_cnt     = 0;
        check_count   = 0;
        t_strap();
        t_reset();
        t_slow();
        t_modes();
        end_sim();
    end
endmodule
